/* logic/serial_prog_link_access.sv */
// Target side of the two-wire programming link: phy, access layer, data bus
`timescale 1ns/1ps
`default_nettype none
module serial_prog_link_access
  import prog_link_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic progClockPin,
  input wire logic progDataIn,
  output logic progDataOut,
  output logic progDataOe,
  output logic [ADDR_W-1:0] busAddr,
  output logic [7:0] busWdata,
  output logic busWrite,
  output logic busRead,
  output logic busIo,
  input wire logic [7:0] busRdata,
  output logic [7:0] guardBits,
  output logic keyValid,
  output logic [63:0] keyValue,
  output logic errorState
);
  // Link side runs on progClockPin; mclk side only watches slow status.
  logic [3:0] rxCnt_reg;
  logic [10:0] rxSh_reg;
  logic rxBusy_reg;
  logic [3:0] zeroRun_reg;
  logic [7:0] instr_reg;
  logic [3:0] opLeft_reg;
  logic [ADDR_W-1:0] pointer_reg;
  logic [7:0] guard_reg;
  logic [7:0] txByte_reg;
  logic [11:0] txSh_reg;
  logic [3:0] txCnt_reg;
  logic [8:0] idleCnt_reg;
  logic prevBit_reg;
  logic drv_reg;
  logic dout_reg;
  logic [63:0] key_reg;
  logic keyDone_reg;
  access_state_t al_reg;
  phy_state_t ph_reg;
  logic errSync1_reg, errSync2_reg;

  function automatic logic parity8(input logic [7:0] d);
    parity8 = ^d;
  endfunction

  // Receive shifter; start bit is a low sample while idle
  wire rxOn = (ph_reg == PH_RX) || (ph_reg == PH_HALT);
  wire rxDone = rxBusy_reg && (rxCnt_reg == 4'(FRAME_BITS - 1));
  wire [7:0] rxByte = rxSh_reg[8:1];
  wire rxParErr = rxDone && (parity8(rxByte) != rxSh_reg[9]);
  wire rxFrmErr = rxDone && (!rxSh_reg[10] || !progDataIn);
  // Break: twelve consecutive low samples; a further low sample is taken as a start bit
  wire rxBreak = rxOn && !progDataIn && (zeroRun_reg == 4'(BREAK_BITS - 1));
  wire rxOk = rxDone && !rxParErr && !rxFrmErr && !rxBreak;

  always_ff @(posedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      rxBusy_reg <= 1'b0;
      rxCnt_reg <= 4'h0;
      rxSh_reg <= 11'h000;
    end else if (!rxOn || rxDone || rxBreak) begin
      rxBusy_reg <= 1'b0;
      rxCnt_reg <= 4'h0;
    end else if (rxBusy_reg) begin
      rxSh_reg <= {progDataIn, rxSh_reg[10:1]};
      rxCnt_reg <= rxCnt_reg + 4'h1;
    end else if (!progDataIn) begin
      rxBusy_reg <= 1'b1;
      rxCnt_reg <= 4'h1;
      rxSh_reg <= 11'h000;
    end
  end

  // Low run counter saturates so long breaks count once
  always_ff @(posedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      zeroRun_reg <= 4'h0;
    end else if (progDataIn || !rxOn) begin
      zeroRun_reg <= 4'h0;
    end else if (zeroRun_reg != 4'hF) begin
      zeroRun_reg <= zeroRun_reg + 4'h1;
    end
  end

  // Opcode classification
  function automatic logic isRead(input logic [7:0] op);
    isRead = ((op & OP_DLD_MASK) == OP_DLD) || ((op & OP_IO_MASK) == OP_IORD) ||
             ((op & OP_CS_MASK) == OP_CSLD);
  endfunction

  // Collision: released high line seen low in transmit
  wire txReleased = (ph_reg == PH_TX) && !drv_reg;
  wire collision = txReleased && !progDataIn;
  wire txLast = (ph_reg == PH_TX) && (txCnt_reg == 4'(FRAME_BITS - 1));
  wire exception = rxParErr || rxFrmErr || rxBreak || collision;
  // Index comes from the byte just taken; instr_reg still holds the previous one
  wire [7:0] cssRead = (rxByte[3:0] == CSS_PHY_CTRL) ? guard_reg : 8'h00;

  // Access layer message sequencer
  always_ff @(posedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      al_reg <= AL_INSTR;
      instr_reg <= 8'h00;
      opLeft_reg <= KEY_CNT_RESET;
      txByte_reg <= 8'h00;
    end else if (rxBreak) begin
      al_reg <= AL_INSTR;
    end else if (exception) begin
      al_reg <= AL_ERROR;
    end else begin
      unique case (al_reg)
        AL_INSTR: if (rxOk) begin
          instr_reg <= rxByte;
          if (isRead(rxByte)) begin
            al_reg <= AL_SEND;
            txByte_reg <= ((rxByte & OP_CS_MASK) == OP_CSLD) ? cssRead : busRdata;
          end else begin
            al_reg <= AL_OPERAND;
            opLeft_reg <= (rxByte == OP_KEY) ? 4'(KEY_BYTES) : 4'h1;
          end
        end
        AL_OPERAND: if (rxOk) begin
          opLeft_reg <= opLeft_reg - 4'h1;
          if (opLeft_reg == 4'h1) al_reg <= AL_INSTR;
        end
        AL_SEND: if (txLast) al_reg <= AL_INSTR;
        AL_ERROR: al_reg <= AL_ERROR;
      endcase
    end
  end

  // Register stores: pointer, guard, key
  wire opStore = (al_reg == AL_OPERAND) && rxOk;
  always_ff @(posedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      pointer_reg <= '0;
      guard_reg <= GUARD_RESET;
      key_reg <= 64'h0000_0000_0000_0000;
      keyDone_reg <= 1'b0;
    end else begin
      if (opStore && ((instr_reg & OP_PST_MASK) == OP_PST)) begin
        if (instr_reg[0]) pointer_reg <= ADDR_W'({rxByte, pointer_reg[7:0]});
        else pointer_reg <= {pointer_reg[ADDR_W-1:8], rxByte};
      end else if ((opStore && ((instr_reg & OP_DST_MASK) == OP_DST) ||
                    (al_reg == AL_SEND && txLast &&
                     (instr_reg & OP_DLD_MASK) == OP_DLD)) &&
                   (instr_reg & POST_INC_BIT) != 8'h00) begin
        pointer_reg <= pointer_reg + ADDR_W'(1);
      end
      if (opStore && (instr_reg & OP_CS_MASK) == OP_CSST &&
          instr_reg[3:0] == CSS_PHY_CTRL) guard_reg <= rxByte;
      if (opStore && instr_reg == OP_KEY) begin
        key_reg <= {rxByte, key_reg[63:8]};
        keyDone_reg <= (opLeft_reg == 4'h1);
      end
    end
  end

  // Data space access: indirect via pointer or direct I/O
  always_comb begin
    busIo = ((instr_reg & OP_IO_MASK) == OP_IORD) || ((instr_reg & OP_IO_MASK) == OP_IOWR);
    busAddr = busIo ? ADDR_W'({instr_reg[6:5], instr_reg[3:0]}) : pointer_reg;
    busWdata = rxByte;
    busWrite = opStore && (((instr_reg & OP_DST_MASK) == OP_DST) ||
                           ((instr_reg & OP_IO_MASK) == OP_IOWR));
    busRead = (al_reg == AL_INSTR) && rxOk && isRead(rxByte) &&
              ((rxByte & OP_CS_MASK) != OP_CSLD);
    if (al_reg == AL_INSTR && rxOk) begin
      busIo = ((rxByte & OP_IO_MASK) == OP_IORD);
      busAddr = busIo ? ADDR_W'({rxByte[6:5], rxByte[3:0]}) : pointer_reg;
    end
  end

  // Phy mode: receive by default, transmit only when sending
  always_ff @(posedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= PH_RX;
      idleCnt_reg <= 9'h000;
      txCnt_reg <= 4'h0;
      txSh_reg <= 12'hFFF;
    end else if (exception && !rxBreak) begin
      // A break is an exception too, but it must release the halt, not renew it
      ph_reg <= PH_HALT;
    end else begin
      unique case (ph_reg)
        PH_RX: if (al_reg == AL_INSTR && rxOk && isRead(rxByte)) begin
          ph_reg <= PH_IDLE;
          idleCnt_reg <= 9'(guard_reg) + 9'(MIN_IDLE_BITS);
        end
        PH_IDLE: begin
          idleCnt_reg <= idleCnt_reg - 9'h001;
          if (idleCnt_reg == 9'h001) begin
            ph_reg <= PH_TX;
            txCnt_reg <= 4'h0;
            // Stops, parity, data, start
            txSh_reg <= {2'b11, parity8(txByte_reg), txByte_reg, 1'b0};
          end
        end
        PH_TX: begin
          txSh_reg <= {1'b1, txSh_reg[11:1]};
          txCnt_reg <= txCnt_reg + 4'h1;
          if (txLast) ph_reg <= PH_RX;
        end
        PH_HALT: if (rxBreak) ph_reg <= PH_RX;
      endcase
    end
  end

  // Output stage updates on falling edge
  wire txBit = txSh_reg[0];
  always_ff @(negedge progClockPin or negedge arst_n) begin
    if (!arst_n) begin
      drv_reg <= 1'b0;
      dout_reg <= 1'b1;
      prevBit_reg <= 1'b0;
    end else if (ph_reg == PH_TX) begin
      dout_reg <= txBit;
      // Zeros always driven, repeated ones released
      drv_reg <= !txBit || !prevBit_reg;
      prevBit_reg <= txBit;
    end else begin
      drv_reg <= 1'b0;
      dout_reg <= 1'b1;
      prevBit_reg <= 1'b0;
    end
  end

  assign progDataOut = dout_reg;
  assign progDataOe = drv_reg;
  assign guardBits = guard_reg;
  assign keyValid = keyDone_reg;
  assign keyValue = key_reg;

  // Error flag crosses to mclk through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      errSync1_reg <= 1'b0;
      errSync2_reg <= 1'b0;
    end else begin
      errSync1_reg <= (al_reg == AL_ERROR);
      errSync2_reg <= errSync1_reg;
    end
  end
  assign errorState = errSync2_reg;

  // Checks on the link clock
  a_zero_driven: assert property (@(posedge progClockPin) disable iff (!arst_n)
    (ph_reg == PH_TX && !dout_reg) |-> drv_reg) else $error("zero not driven");
  a_collision_err: assert property (@(posedge progClockPin) disable iff (!arst_n)
    collision |=> (al_reg == AL_ERROR && ph_reg == PH_HALT)) else $error("collision missed");
  a_break_recover: assert property (@(posedge progClockPin) disable iff (!arst_n)
    rxBreak |=> al_reg == AL_INSTR) else $error("break no recover");
  a_error_hold: assert property (@(posedge progClockPin) disable iff (!arst_n)
    (al_reg == AL_ERROR && !rxBreak) |=> al_reg == AL_ERROR) else $error("left error");
  // A read instruction taken: receive on one edge, idle countdown from the next
  sequence s_read_taken;
    ph_reg == PH_RX ##1 ph_reg == PH_IDLE;
  endsequence
  a_guard_idle: assert property (@(posedge progClockPin) disable iff (!arst_n)
    s_read_taken |-> idleCnt_reg == 9'(guard_reg) + 9'(MIN_IDLE_BITS))
    else $error("idle count");
  a_frame_len: assert property (@(posedge progClockPin) disable iff (!arst_n)
    ($rose(ph_reg == PH_TX) && !exception) |-> txCnt_reg == 4'h0) else $error("tx start");
  a_stop_high: assert property (@(posedge progClockPin) disable iff (!arst_n)
    (ph_reg == PH_TX && txCnt_reg >= 4'hA) |-> txBit) else $error("stop low");
  a_rx_idle: assert property (@(posedge progClockPin) disable iff (!arst_n)
    (ph_reg != PH_TX) |=> !drv_reg || ph_reg == PH_TX) else $error("driving in rx");
  a_key_count: assert property (@(posedge progClockPin) disable iff (!arst_n)
    (al_reg == AL_INSTR && rxOk && rxByte == OP_KEY && !exception)
    |=> opLeft_reg == 4'(KEY_BYTES)) else $error("key count");
endmodule
`default_nettype wire

/* shared/prog_link_pkg.sv */
// Shared constants and types for the serial programming link target
package prog_link_pkg;
  // Frame layout: start, 8 data, parity, 2 stops
  localparam int FRAME_BITS = 12;
  localparam int DATA_BITS = 8;
  localparam int BREAK_BITS = 12;
  localparam int MIN_IDLE_BITS = 2;
  localparam int KEY_BYTES = 8;
  // Guard time default after reset, in bit periods
  localparam logic [7:0] GUARD_RESET = 8'h80;
  localparam logic [3:0] KEY_CNT_RESET = 4'h0;
  // Opcode patterns
  localparam logic [7:0] OP_DLD_MASK = 8'hFB;
  localparam logic [7:0] OP_DLD = 8'h20;
  localparam logic [7:0] OP_DST_MASK = 8'hFB;
  localparam logic [7:0] OP_DST = 8'h60;
  localparam logic [7:0] OP_PST_MASK = 8'hFE;
  localparam logic [7:0] OP_PST = 8'h68;
  localparam logic [7:0] OP_IO_MASK = 8'h90;
  localparam logic [7:0] OP_IORD = 8'h10;
  localparam logic [7:0] OP_IOWR = 8'h90;
  localparam logic [7:0] OP_CS_MASK = 8'hF0;
  localparam logic [7:0] OP_CSLD = 8'h80;
  localparam logic [7:0] OP_CSST = 8'hC0;
  localparam logic [7:0] OP_KEY = 8'hE0;
  localparam logic [7:0] POST_INC_BIT = 8'h04;
  // Control/status space index of the physical-layer control register
  localparam logic [3:0] CSS_PHY_CTRL = 4'h2;

  typedef enum logic [3:0] {
    AL_INSTR = 4'b0001,
    AL_OPERAND = 4'b0010,
    AL_SEND = 4'b0100,
    AL_ERROR = 4'b1000
  } access_state_t;

  typedef enum logic [3:0] {
    PH_RX = 4'b0001,
    PH_IDLE = 4'b0010,
    PH_TX = 4'b0100,
    PH_HALT = 4'b1000
  } phy_state_t;
endpackage

/* tb/prog_link_programmer.sv */
// Behavioural programmer that clocks the link and shares its data line
`timescale 1ns/1ps
`default_nettype none
module prog_link_programmer
  import prog_link_pkg::*;
(
  output logic progClk,
  output logic progOut,
  output logic progOe,
  input wire logic dataLine,
  input wire logic devOe
);
  // Clock rests high between frames, line left to the pull-up
  initial begin
    progClk = 1'b1;
    progOut = 1'b1;
    progOe = 1'b0;
  end
  // One period: change on the falling edge, sample on the rising edge
  task automatic tick(input logic drv, input logic val, output logic s, output logic oe);
    progClk = 1'b0;
    progOe = drv;
    progOut = val;
    #62.5;
    progClk = 1'b1;
    s = dataLine;
    oe = devOe;
    #62.5;
  endtask
  task automatic idle(input int n);
    logic s, oe;
    repeat (n) tick(1'b0, 1'b1, s, oe);
  endtask
  // A released bit ahead of every frame covers our own turnaround
  task automatic send(input logic [7:0] d, input logic badPar);
    logic [11:0] f;
    logic s, oe;
    f = {2'b11, (^d ^ badPar), d, 1'b0};
    idle(1);
    for (int i = 0; i < FRAME_BITS; i++) tick(1'b1, f[i], s, oe);
  endtask
  task automatic brk();
    logic s, oe;
    for (int i = 0; i < BREAK_BITS; i++) tick(1'b1, 1'b0, s, oe);
    idle(1);
  endtask
  // Waits for the answer counting idle bits; clash pulls the line low at that bit
  task automatic recv(input int clash, output logic [7:0] d, output int idles, output logic ok);
    logic [11:0] f;
    logic s, oe;
    idles = 0;
    tick(1'b0, 1'b1, s, oe);
    while (s === 1'b1 && idles < 400) begin
      idles++;
      tick(1'b0, 1'b1, s, oe);
    end
    f[0] = s;
    ok = (oe === 1'b1);
    for (int i = 1; i < FRAME_BITS; i++) begin
      tick(i == clash, 1'b0, s, oe);
      f[i] = s;
      if (oe !== (!f[i] || !f[i-1])) ok = 1'b0;
    end
    d = f[8:1];
    if (f[0] !== 1'b0 || f[9] !== ^d || f[11:10] !== 2'b11) ok = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/serial_prog_link_access_test.sv */
// Self-checking bench for the programming link target
`timescale 1ns/1ps
`default_nettype none
module serial_prog_link_access_test
  import prog_link_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic progClk, progOut, progOe, devOut, devOe, dataLine;
  logic [15:0] busAddr, wrAddr, rdAddr;
  logic [7:0] busWdata, busRdata, guardBits, wrData, d;
  logic busWrite, busRead, busIo, wrIo, rdIo, keyValid, errorState, ok;
  logic [63:0] keyValue;
  int n_errors = 0;
  int compares = 0;
  int idles;
  always #5 mclk = ~mclk;
  // A driven zero wins; the pull-up holds the line where nobody drives
  assign dataLine = (devOe ? devOut : 1'b1) & (progOe ? progOut : 1'b1);
  // Read data follows the address, so every answer is predictable
  assign busRdata = busAddr[7:0] ^ 8'h5A;
  serial_prog_link_access #(.ADDR_W(16)) u_serial_prog_link_access (
    .mclk(mclk), .arst_n(arst_n), .progClockPin(progClk), .progDataIn(dataLine),
    .progDataOut(devOut), .progDataOe(devOe), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busIo(busIo), .busRdata(busRdata),
    .guardBits(guardBits), .keyValid(keyValid), .keyValue(keyValue),
    .errorState(errorState));
  prog_link_programmer u_prog_link_programmer (.progClk(progClk), .progOut(progOut),
    .progOe(progOe), .dataLine(dataLine), .devOe(devOe));
  // Strobes last until the next link edge, which may never come; sample on mclk
  always @(posedge mclk) begin
    if (busRead === 1'b1) begin
      rdAddr <= busAddr;
      rdIo <= busIo;
    end
    if (busWrite === 1'b1) begin
      wrAddr <= busAddr;
      wrData <= busWdata;
      wrIo <= busIo;
    end
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp, input int idl);
    u_prog_link_programmer.send(op, 1'b0);
    u_prog_link_programmer.recv(99, d, idles, ok);
    check("answer", exp, d);
    check("idle bits", idl, idles);
    check("frame shape", 1, ok);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] v);
    u_prog_link_programmer.send(op, 1'b0);
    u_prog_link_programmer.send(v, 1'b0);
  endtask
  task automatic t_reset();
    check("guard", GUARD_RESET, guardBits);
    check("oe", 0, devOe);
    check("error", 0, errorState);
  endtask
  task automatic t_io();
    rd(8'h5B, 8'h2B ^ 8'h5A, 130);
    check("rd addr", 16'h002B, rdAddr);
    check("rd io", 1, rdIo);
    wr(8'hB1, 8'h3C);
    check("wr addr", 16'h0011, wrAddr);
    check("wr data", 8'h3C, wrData);
    check("wr io", 1, wrIo);
  endtask
  task automatic t_guard();
    wr(8'hC2, 8'h05);
    check("guard set", 8'h05, guardBits);
    rd(8'h82, 8'h05, 7);
  endtask
  task automatic t_ptr();
    wr(8'h68, 8'h34);
    wr(8'h69, 8'h12);
    wr(8'h64, 8'hA5);
    check("st addr", 16'h1234, wrAddr);
    check("st io", 0, wrIo);
    rd(8'h20, 8'h35 ^ 8'h5A, 7);
    check("ld addr", 16'h1235, rdAddr);
    rd(8'h24, 8'h35 ^ 8'h5A, 7);
    check("ldi addr", 16'h1235, rdAddr);
    rd(8'h20, 8'h36 ^ 8'h5A, 7);
    check("ld inc addr", 16'h1236, rdAddr);
  endtask
  task automatic t_key();
    u_prog_link_programmer.send(OP_KEY, 1'b0);
    for (int i = 1; i <= KEY_BYTES; i++) u_prog_link_programmer.send(8'(i), 1'b0);
    check("key valid", 1, keyValid);
    check("key", 64'h0807060504030201, keyValue);
  endtask
  // Writes in error state must be dropped; two breaks bring the link back
  task automatic recover(input logic [7:0] old);
    wr(8'hC2, 8'h09);
    check("ignored", old, guardBits);
    u_prog_link_programmer.brk();
    u_prog_link_programmer.brk();
    repeat (4) @(posedge mclk);
    check("error cleared", 0, errorState);
    wr(8'hC2, 8'h03);
    check("guard again", 8'h03, guardBits);
    rd(8'h82, 8'h03, 5);
  endtask
  task automatic t_clash();
    u_prog_link_programmer.send(8'h5B, 1'b0);
    u_prog_link_programmer.recv(11, d, idles, ok);
    repeat (4) @(posedge mclk);
    check("error on clash", 1, errorState);
    check("oe off", 0, devOe);
    recover(8'h05);
  endtask
  task automatic t_parity();
    u_prog_link_programmer.send(8'hC2, 1'b1);
    repeat (4) @(posedge mclk);
    check("error on parity", 1, errorState);
    recover(8'h03);
  endtask
  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    fork
      u_prog_link_programmer.idle(2);
      repeat (5) @(posedge mclk);
    join
    @(posedge mclk) arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_io();
    t_guard();
    t_ptr();
    t_key();
    t_clash();
    t_parity();
    end_of_test();
  end
  // The whole run needs about an eighth of this span
  initial begin
    #800000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
